// file: include/mas_pkg.sv
// Shared widths, reset values, operation codes and sequencer states for the skip/table datapath.
package mas_pkg;

  localparam int          DATA_W      = 8;
  localparam int          PROG_AW     = 13;
  localparam int          PROG_DW     = 16;
  localparam int          PAGE_W      = 5;
  localparam int          BIT_SEL_W   = 3;
  localparam int          NIB_W       = 4;
  localparam int          SIGN_POS    = 7;
  localparam int          LSB_POS     = 0;
  localparam logic [7:0]  BYTE_ONES   = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  BYTE_ONE    = 8'h01;
  localparam logic [7:0]  WORK_RESET  = 8'h00;
  localparam logic [7:0]  PTR_RESET   = 8'h00;
  localparam logic [7:0]  LATCH_RESET = 8'h00;
  localparam logic [12:0] PADDR_RESET = 13'h0000;
  localparam logic [4:0]  LAST_PAGE   = 5'h1F;
  localparam logic        FLAG_RESET  = 1'b0;
  localparam int          SKIP_CYCLES = 2;
  localparam int          TBL_CYCLES  = 2;

  // Operation codes; the bit forms of skip and set use the bit select port.
  typedef enum logic [4:0] {
    OP_NONE,
    OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING,
    OP_SUBTRACT_BORROW_REG,
    OP_SUBTRACT_BORROW_TO_MEMORY,
    OP_SUBTRACT_REG,
    OP_SUBTRACT_TO_MEMORY,
    OP_DECREMENT_SKIP_NULL,
    OP_DECREMENT_SKIP_NULL_TO_WORKING,
    OP_INCREMENT_SKIP_NULL,
    OP_INCREMENT_SKIP_NULL_TO_WORKING,
    OP_SKIP_NONNULL,
    OP_SKIP_NONNULL_BIT,
    OP_SKIP_ON_NULL,
    OP_SKIP_ON_NULL_BIT,
    OP_COPY_SKIP_ON_NULL,
    OP_SET_ALL,
    OP_SET_BIT,
    OP_NIBBLE_SWAP,
    OP_NIBBLE_EXCHANGE_TO_WORKING,
    OP_PROGRAM_WORD_FETCH,
    OP_LAST_PAGE_WORD_FETCH,
    OP_POINTER_BUMP_WORD_FETCH,
    OP_POINTER_BUMP_LAST_PAGE_FETCH,
    OP_EXCLUSIVE_OR_REG,
    OP_EXCLUSIVE_OR_TO_MEMORY
  } mas_op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DUMMY,
    ST_TBL_WAIT
  } mas_state_e;

endpackage

// file: include/mas_sub_if.sv
// Operand and result bundle between the datapath and its subtractor.
`timescale 1ns/1ps
interface mas_sub_if;
  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic       carry_in;
  logic       use_carry;
  logic [7:0] diff;
  logic       carry_out;
  logic       nib_carry;
  logic       overflow;

  modport calc (input minuend, input subtrahend, input carry_in, input use_carry,
                output diff, output carry_out, output nib_carry, output overflow);
  modport user (output minuend, output subtrahend, output carry_in, output use_carry,
                input diff, input carry_out, input nib_carry, input overflow);
endinterface

// file: hdl/mas_subtractor.sv
// Eight-bit subtractor with borrow-in and carry, nibble carry and overflow outputs.
`timescale 1ns/1ps
module mas_subtractor (
  input wire logic clk_sys,
  input wire logic rst_b,
  mas_sub_if.calc  sub
);

  logic       borrow_in;
  logic [8:0] wide_diff;
  logic [4:0] nib_diff;

  // Carry set means no borrow, so the borrow term is the inverted carry.
  assign borrow_in     = sub.use_carry & ~sub.carry_in;
  assign wide_diff     = {1'b0, sub.minuend} - {1'b0, sub.subtrahend} - {8'h00, borrow_in};
  assign nib_diff      = {1'b0, sub.minuend[3:0]} - {1'b0, sub.subtrahend[3:0]} - {4'h0, borrow_in};
  assign sub.diff      = wide_diff[7:0];
  assign sub.carry_out = ~wide_diff[8];
  assign sub.nib_carry = ~nib_diff[4];
  assign sub.overflow  = (sub.minuend[7] ^ sub.subtrahend[7]) & (sub.minuend[7] ^ wide_diff[7]);

  a_sub_carry_sense: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    sub.carry_out == ({1'b0, sub.minuend} >= ({1'b0, sub.subtrahend} + {8'h00, borrow_in})))
    else $error("subtract carry does not match borrow sense");

  a_sub_difference: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (sub.diff + sub.subtrahend + {7'h00, borrow_in}) == sub.minuend)
    else $error("subtract difference is wrong");

endmodule

// file: hdl/mas_alu_skip_table.sv
// Datapath for rotate, subtract, skip, set, swap, table read and exclusive-or operations.
`timescale 1ns/1ps
// Operation
// - Rotate right through carry into working register
// - Subtract operand and inverted carry into working
// - Carry clear on negative, set otherwise
// - Subtracts update all six arithmetic flags
// - Memory forms store difference into memory
// - Plain subtract ignores carry, result to working
// - Decrement memory, write back, skip on zero
// - Decrement into working, skip on zero
// - Increment memory, write back, skip on zero
// - Increment into working, skip on zero
// - Skipping instruction takes two cycles
// - Skip when byte or bit nonzero
// - Skip when byte zero, flags untouched
// - Copy byte to working, skip if zero
// - Bit form skips when bit is zero
// - Set writes all ones or one bit
// - Nibble swap memory in place
// - Nibble swap into working, memory kept
// - Table read via both pointers
// - Table read from last page, low pointer
// - Bump low pointer before table read
// - Exclusive-or to working or memory, null flag
module mas_alu_skip_table (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST_B,
  input  wire logic                 OP_VALID,
  input  wire mas_pkg::mas_op_e     OP_CODE,
  input  wire logic                 USE_IMM,
  input  wire logic [7:0]           IMM_DATA,
  input  wire logic [2:0]           BIT_SEL,
  input  wire logic [7:0]           MEM_ADDR_IN,
  input  wire logic [7:0]           MEM_RDATA,
  input  wire logic [15:0]          PROG_RDATA,
  input  wire logic                 CARRY_LOAD,
  input  wire logic                 CARRY_WDATA,
  input  wire logic                 WORK_LOAD,
  input  wire logic [7:0]           WORK_WDATA,
  input  wire logic                 PTR_LOW_LOAD,
  input  wire logic                 PTR_HIGH_LOAD,
  input  wire logic [7:0]           PTR_WDATA,
  output logic                      READY,
  output logic [7:0]                WORK_REG,
  output logic                      BORROW_OUT_FLAG,
  output logic                      SIGNED_RANGE_FLAG,
  output logic                      RESULT_NULL_FLAG,
  output logic                      NIBBLE_BORROW_FLAG,
  output logic                      SIGNED_BORROW_FLAG,
  output logic                      CHAINED_NULL_FLAG,
  output logic                      MEM_WE,
  output logic [7:0]                MEM_WADDR,
  output logic [7:0]                MEM_WDATA,
  output logic                      SKIP,
  output logic                      PROG_RD,
  output logic [12:0]               PROG_ADDR,
  output logic [7:0]                TBL_PTR_LOW,
  output logic [7:0]                TBL_PTR_HIGH,
  output logic [7:0]                TBL_HIGH_LATCH
);

  mas_pkg::mas_state_e state_q;
  mas_pkg::mas_state_e state_d;
  logic [7:0]  work_q;
  logic        carry_q;
  logic        range_q;
  logic        null_q;
  logic        nib_q;
  logic        sbor_q;
  logic        cnull_q;
  logic        mem_we_q;
  logic [7:0]  mem_waddr_q;
  logic [7:0]  mem_wdata_q;
  logic        skip_q;
  logic        prog_rd_q;
  logic [12:0] prog_addr_q;
  logic [7:0]  ptr_low_q;
  logic [7:0]  ptr_high_q;
  logic [7:0]  latch_q;

  logic        take;
  logic        imm_sel;
  logic [7:0]  operand;
  logic [7:0]  rot_val;
  logic [7:0]  dec_val;
  logic [7:0]  inc_val;
  logic [7:0]  swap_val;
  logic [7:0]  bit_mask;
  logic        bit_on;
  logic        byte_null;
  logic [7:0]  xor_val;
  logic [7:0]  ptr_low_next;
  logic [12:0] tbl_addr;
  logic        tbl_wait;
  logic [7:0]  res;
  logic        wr_work;
  logic        wr_mem;
  logic        skip_hit;
  logic        upd_sub;
  logic        upd_null;
  logic        upd_rot;
  logic        use_carry;
  logic        tbl_op;
  logic        tbl_bump;
  logic        tbl_last;

  mas_sub_if sub_bus ();

  mas_subtractor u_sub (
    .clk_sys (CLK_SYS),
    .rst_b   (RST_B),
    .sub     (sub_bus.calc)
  );

  // True for the forms whose subtrahend or mixing operand may be immediate data.
  function automatic logic takes_imm(input mas_pkg::mas_op_e op);
    takes_imm = (op == mas_pkg::OP_SUBTRACT_BORROW_REG) || (op == mas_pkg::OP_SUBTRACT_REG) ||
                (op == mas_pkg::OP_EXCLUSIVE_OR_REG);
  endfunction

  // True for the subtract family, with or without carry.
  function automatic logic is_subtract(input mas_pkg::mas_op_e op);
    is_subtract = (op == mas_pkg::OP_SUBTRACT_BORROW_REG) || (op == mas_pkg::OP_SUBTRACT_BORROW_TO_MEMORY) ||
                  (op == mas_pkg::OP_SUBTRACT_REG) || (op == mas_pkg::OP_SUBTRACT_TO_MEMORY);
  endfunction

  assign take      = OP_VALID & READY;
  assign READY     = (state_q == mas_pkg::ST_IDLE);
  assign tbl_wait  = (state_q == mas_pkg::ST_TBL_WAIT);
  assign imm_sel   = USE_IMM & takes_imm(OP_CODE);
  assign operand   = imm_sel ? IMM_DATA : MEM_RDATA;
  assign rot_val   = {carry_q, MEM_RDATA[7:1]};
  assign dec_val   = MEM_RDATA - mas_pkg::BYTE_ONE;
  assign inc_val   = MEM_RDATA + mas_pkg::BYTE_ONE;
  assign swap_val  = {MEM_RDATA[3:0], MEM_RDATA[7:4]};
  assign bit_mask  = mas_pkg::BYTE_ONE << BIT_SEL;
  assign bit_on    = (MEM_RDATA & bit_mask) != mas_pkg::BYTE_ZERO;
  assign byte_null = (MEM_RDATA == mas_pkg::BYTE_ZERO);
  assign xor_val   = work_q ^ operand;

  assign sub_bus.minuend    = work_q;
  assign sub_bus.subtrahend = operand;
  assign sub_bus.carry_in   = carry_q;
  assign sub_bus.use_carry  = use_carry;

  // The pointer bump is folded into the address so the read sees the updated pointer.
  assign ptr_low_next = tbl_bump ? (ptr_low_q + mas_pkg::BYTE_ONE) : ptr_low_q;
  assign tbl_addr     = tbl_last ? {mas_pkg::LAST_PAGE, ptr_low_next}
                                 : {ptr_high_q[mas_pkg::PAGE_W-1:0], ptr_low_next};

  always_comb begin
    res       = mas_pkg::BYTE_ZERO;
    wr_work   = 1'b0;
    wr_mem    = 1'b0;
    skip_hit  = 1'b0;
    upd_sub   = 1'b0;
    upd_null  = 1'b0;
    upd_rot   = 1'b0;
    use_carry = 1'b0;
    tbl_op    = 1'b0;
    tbl_bump  = 1'b0;
    tbl_last  = 1'b0;
    case (OP_CODE)
      mas_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING: begin
        res     = rot_val;
        wr_work = 1'b1;
        upd_rot = 1'b1;
      end
      mas_pkg::OP_SUBTRACT_BORROW_REG: begin
        res       = sub_bus.diff;
        wr_work   = 1'b1;
        upd_sub   = 1'b1;
        use_carry = 1'b1;
      end
      mas_pkg::OP_SUBTRACT_BORROW_TO_MEMORY: begin
        res       = sub_bus.diff;
        wr_mem    = 1'b1;
        upd_sub   = 1'b1;
        use_carry = 1'b1;
      end
      mas_pkg::OP_SUBTRACT_REG: begin
        res     = sub_bus.diff;
        wr_work = 1'b1;
        upd_sub = 1'b1;
      end
      mas_pkg::OP_SUBTRACT_TO_MEMORY: begin
        res     = sub_bus.diff;
        wr_mem  = 1'b1;
        upd_sub = 1'b1;
      end
      mas_pkg::OP_DECREMENT_SKIP_NULL: begin
        res      = dec_val;
        wr_mem   = 1'b1;
        skip_hit = (dec_val == mas_pkg::BYTE_ZERO);
      end
      mas_pkg::OP_DECREMENT_SKIP_NULL_TO_WORKING: begin
        res      = dec_val;
        wr_work  = 1'b1;
        skip_hit = (dec_val == mas_pkg::BYTE_ZERO);
      end
      mas_pkg::OP_INCREMENT_SKIP_NULL: begin
        res      = inc_val;
        wr_mem   = 1'b1;
        skip_hit = (inc_val == mas_pkg::BYTE_ZERO);
      end
      mas_pkg::OP_INCREMENT_SKIP_NULL_TO_WORKING: begin
        res      = inc_val;
        wr_work  = 1'b1;
        skip_hit = (inc_val == mas_pkg::BYTE_ZERO);
      end
      mas_pkg::OP_SKIP_NONNULL:     skip_hit = ~byte_null;
      mas_pkg::OP_SKIP_NONNULL_BIT: skip_hit = bit_on;
      mas_pkg::OP_SKIP_ON_NULL:     skip_hit = byte_null;
      mas_pkg::OP_SKIP_ON_NULL_BIT: skip_hit = ~bit_on;
      mas_pkg::OP_COPY_SKIP_ON_NULL: begin
        res      = MEM_RDATA;
        wr_work  = 1'b1;
        skip_hit = byte_null;
      end
      mas_pkg::OP_SET_ALL: begin
        res    = mas_pkg::BYTE_ONES;
        wr_mem = 1'b1;
      end
      mas_pkg::OP_SET_BIT: begin
        res    = MEM_RDATA | bit_mask;
        wr_mem = 1'b1;
      end
      mas_pkg::OP_NIBBLE_SWAP: begin
        res    = swap_val;
        wr_mem = 1'b1;
      end
      mas_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING: begin
        res     = swap_val;
        wr_work = 1'b1;
      end
      mas_pkg::OP_PROGRAM_WORD_FETCH:   tbl_op = 1'b1;
      mas_pkg::OP_LAST_PAGE_WORD_FETCH: begin
        tbl_op   = 1'b1;
        tbl_last = 1'b1;
      end
      mas_pkg::OP_POINTER_BUMP_WORD_FETCH: begin
        tbl_op   = 1'b1;
        tbl_bump = 1'b1;
      end
      mas_pkg::OP_POINTER_BUMP_LAST_PAGE_FETCH: begin
        tbl_op   = 1'b1;
        tbl_bump = 1'b1;
        tbl_last = 1'b1;
      end
      mas_pkg::OP_EXCLUSIVE_OR_REG: begin
        res      = xor_val;
        wr_work  = 1'b1;
        upd_null = 1'b1;
      end
      mas_pkg::OP_EXCLUSIVE_OR_TO_MEMORY: begin
        res      = xor_val;
        wr_mem   = 1'b1;
        upd_null = 1'b1;
      end
      default: ;
    endcase
  end

  // A taken skip inserts one dummy cycle; a table read waits one cycle for program data.
  always_comb begin
    state_d = state_q;
    case (state_q)
      mas_pkg::ST_IDLE: begin
        if (take && skip_hit) begin
          state_d = mas_pkg::ST_DUMMY;
        end else if (take && tbl_op) begin
          state_d = mas_pkg::ST_TBL_WAIT;
        end
      end
      mas_pkg::ST_DUMMY:    state_d = mas_pkg::ST_IDLE;
      mas_pkg::ST_TBL_WAIT: state_d = mas_pkg::ST_IDLE;
      default:              state_d = mas_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= mas_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // An instruction result takes priority over a direct load in the same cycle.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      work_q <= mas_pkg::WORK_RESET;
    end else if (take && wr_work) begin
      work_q <= res;
    end else if (WORK_LOAD) begin
      work_q <= WORK_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      carry_q <= mas_pkg::FLAG_RESET;
      range_q <= mas_pkg::FLAG_RESET;
      nib_q   <= mas_pkg::FLAG_RESET;
      sbor_q  <= mas_pkg::FLAG_RESET;
      cnull_q <= mas_pkg::FLAG_RESET;
    end else if (take && upd_sub) begin
      carry_q <= sub_bus.carry_out;
      range_q <= sub_bus.overflow;
      nib_q   <= sub_bus.nib_carry;
      sbor_q  <= ~(sub_bus.overflow ^ sub_bus.diff[mas_pkg::SIGN_POS]);
      cnull_q <= (sub_bus.diff == mas_pkg::BYTE_ZERO) & (cnull_q | ~use_carry);
    end else if (take && upd_rot) begin
      carry_q <= MEM_RDATA[mas_pkg::LSB_POS];
    end else if (CARRY_LOAD) begin
      carry_q <= CARRY_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      null_q <= mas_pkg::FLAG_RESET;
    end else if (take && (upd_sub || upd_null)) begin
      null_q <= (res == mas_pkg::BYTE_ZERO);
    end
  end

  // Memory write port: one pulse per write, address held from the taking edge.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      mem_we_q    <= 1'b0;
      mem_waddr_q <= mas_pkg::BYTE_ZERO;
      mem_wdata_q <= mas_pkg::BYTE_ZERO;
      skip_q      <= 1'b0;
    end else begin
      mem_we_q    <= (take && wr_mem) || tbl_wait;
      mem_waddr_q <= take ? MEM_ADDR_IN : mem_waddr_q;
      mem_wdata_q <= tbl_wait ? PROG_RDATA[7:0] : (take ? res : mem_wdata_q);
      skip_q      <= take && skip_hit;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      prog_rd_q   <= 1'b0;
      prog_addr_q <= mas_pkg::PADDR_RESET;
      latch_q     <= mas_pkg::LATCH_RESET;
    end else begin
      prog_rd_q   <= take && tbl_op;
      prog_addr_q <= (take && tbl_op) ? tbl_addr : prog_addr_q;
      latch_q     <= tbl_wait ? PROG_RDATA[15:8] : latch_q;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ptr_low_q  <= mas_pkg::PTR_RESET;
      ptr_high_q <= mas_pkg::PTR_RESET;
    end else begin
      ptr_low_q  <= (take && tbl_op) ? ptr_low_next : (PTR_LOW_LOAD ? PTR_WDATA : ptr_low_q);
      ptr_high_q <= PTR_HIGH_LOAD ? PTR_WDATA : ptr_high_q;
    end
  end

  assign WORK_REG           = work_q;
  assign BORROW_OUT_FLAG    = carry_q;
  assign SIGNED_RANGE_FLAG  = range_q;
  assign RESULT_NULL_FLAG   = null_q;
  assign NIBBLE_BORROW_FLAG = nib_q;
  assign SIGNED_BORROW_FLAG = sbor_q;
  assign CHAINED_NULL_FLAG  = cnull_q;
  assign MEM_WE             = mem_we_q;
  assign MEM_WADDR          = mem_waddr_q;
  assign MEM_WDATA          = mem_wdata_q;
  assign SKIP               = skip_q;
  assign PROG_RD            = prog_rd_q;
  assign PROG_ADDR          = prog_addr_q;
  assign TBL_PTR_LOW        = ptr_low_q;
  assign TBL_PTR_HIGH       = ptr_high_q;
  assign TBL_HIGH_LATCH     = latch_q;

  a_rotate_carry_work: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    take && (OP_CODE == mas_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING)
    |=> WORK_REG == {$past(carry_q), $past(MEM_RDATA[7:1])} && carry_q == $past(MEM_RDATA[0]) && !MEM_WE)
    else $error("rotate through carry gave wrong working value or carry");

  a_borrow_sub_work: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    take && (OP_CODE == mas_pkg::OP_SUBTRACT_BORROW_REG)
    |=> WORK_REG == ($past(work_q) - $past(operand) - {7'h00, ~$past(carry_q)}))
    else $error("subtract with borrow gave wrong working value");

  a_sub_flag_null: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    take && is_subtract(OP_CODE) |=> RESULT_NULL_FLAG == ($past(res) == 8'h00) && BORROW_OUT_FLAG == $past(sub_bus.carry_out))
    else $error("subtract flags not updated from result");

  a_sub_memory_form: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    take && ((OP_CODE == mas_pkg::OP_SUBTRACT_TO_MEMORY) || (OP_CODE == mas_pkg::OP_SUBTRACT_BORROW_TO_MEMORY))
    |=> MEM_WE && MEM_WDATA == $past(sub_bus.diff) && WORK_REG == $past(work_q))
    else $error("memory subtract did not store into memory only");

  a_decrement_skip: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    take && (OP_CODE == mas_pkg::OP_DECREMENT_SKIP_NULL)
    |=> MEM_WE && MEM_WDATA == $past(MEM_RDATA) - 8'h01 && SKIP == (MEM_WDATA == 8'h00) && $stable(RESULT_NULL_FLAG))
    else $error("decrement and skip misbehaved");

  a_skip_two_cycles: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    SKIP |-> !READY ##1 READY)
    else $error("skip did not take exactly one dummy cycle");

  a_skip_null_test: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    take && (OP_CODE == mas_pkg::OP_SKIP_ON_NULL) |=> SKIP == ($past(MEM_RDATA) == 8'h00) && !MEM_WE)
    else $error("skip on null decided wrongly");

  a_set_all_ones: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    take && (OP_CODE == mas_pkg::OP_SET_ALL) |=> MEM_WE && MEM_WDATA == 8'hFF && $stable(BORROW_OUT_FLAG))
    else $error("set did not write all ones");

  a_table_read_seq: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    take && tbl_op |=> PROG_RD && !MEM_WE ##1 MEM_WE && MEM_WDATA == $past(PROG_RDATA[7:0])
    && TBL_HIGH_LATCH == $past(PROG_RDATA[15:8]))
    else $error("table read sequence broken");

  a_pointer_bump: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    take && (OP_CODE == mas_pkg::OP_POINTER_BUMP_LAST_PAGE_FETCH)
    |=> TBL_PTR_LOW == $past(ptr_low_q) + 8'h01 && PROG_ADDR == {5'h1F, TBL_PTR_LOW})
    else $error("pointer bump or last page address wrong");

  c_skip_taken: cover property (@(posedge CLK_SYS) disable iff (!RST_B) SKIP);
  c_table_done: cover property (@(posedge CLK_SYS) disable iff (!RST_B) PROG_RD ##1 MEM_WE);
  c_sub_negative: cover property (@(posedge CLK_SYS) disable iff (!RST_B)
    take && upd_sub && !sub_bus.carry_out);

endmodule

// file: verification/mas_mem_model.sv
// Data memory and program memory model that answers the datapath.
`timescale 1ns/1ps
module mas_mem_model (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  rd_addr,
  output logic [7:0]       rd_data,
  input  wire logic        we,
  input  wire logic [7:0]  waddr,
  input  wire logic [7:0]  wdata,
  input  wire logic        prog_rd,
  input  wire logic [12:0] prog_addr,
  output logic [15:0]      prog_data
);
  logic [7:0]  mem [256];
  logic [15:0] junk_q = 16'hA5C3;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37);
  // A write in flight is forwarded, so back-to-back operations on one byte see fresh data.
  assign rd_data = (we && waddr == rd_addr) ? wdata : mem[rd_addr];
  // Outside a fetch the bus toggles every cycle, so a stray sample cannot match by luck.
  assign prog_data = prog_rd ? {3'h5, prog_addr} : junk_q;
  always @(posedge clk_sys) begin
    junk_q <= ~junk_q;
    if (we) mem[waddr] <= wdata;
  end
endmodule

// file: verification/tb_mas_alu_skip_table.sv
// Self-checking bench: corner and random operations against a memory model.
`timescale 1ns/1ps
module tb_mas_alu_skip_table;
  logic             clk_sys = 1'b0;
  logic             rst_b, op_valid, use_imm, c_ld, c_wd, w_ld, pl_ld, ph_ld;
  mas_pkg::mas_op_e op_code;
  logic [7:0]       imm, addr, w_wd, p_wd, rdata, work, m_wa, m_wd, p_lo, p_hi, latch, lo_x, hi_x;
  logic [2:0]       bsel;
  logic [15:0]      pdata;
  logic [12:0]      paddr;
  logic             ready, f_c, f_ov, f_z, f_ac, f_sc, f_cz, m_we, skip, p_rd;
  int               fail_count = 0;
  int               total_checks = 0;
  integer           seed = 32'hdf425790;
  logic [31:0]      r;
  always #5 clk_sys = ~clk_sys;
  mas_alu_skip_table DUT (.CLK_SYS(clk_sys), .RST_B(rst_b), .OP_VALID(op_valid), .OP_CODE(op_code),
    .USE_IMM(use_imm), .IMM_DATA(imm), .BIT_SEL(bsel), .MEM_ADDR_IN(addr), .MEM_RDATA(rdata), .PROG_RDATA(pdata),
    .CARRY_LOAD(c_ld), .CARRY_WDATA(c_wd), .WORK_LOAD(w_ld), .WORK_WDATA(w_wd), .PTR_LOW_LOAD(pl_ld),
    .PTR_HIGH_LOAD(ph_ld), .PTR_WDATA(p_wd), .READY(ready), .WORK_REG(work), .BORROW_OUT_FLAG(f_c),
    .SIGNED_RANGE_FLAG(f_ov), .RESULT_NULL_FLAG(f_z), .NIBBLE_BORROW_FLAG(f_ac), .SIGNED_BORROW_FLAG(f_sc),
    .CHAINED_NULL_FLAG(f_cz), .MEM_WE(m_we), .MEM_WADDR(m_wa), .MEM_WDATA(m_wd), .SKIP(skip), .PROG_RD(p_rd),
    .PROG_ADDR(paddr), .TBL_PTR_LOW(p_lo), .TBL_PTR_HIGH(p_hi), .TBL_HIGH_LATCH(latch));
  mas_mem_model MEM (.clk_sys(clk_sys), .rd_addr(addr), .rd_data(rdata), .we(m_we), .waddr(m_wa), .wdata(m_wd),
    .prog_rd(p_rd), .prog_addr(paddr), .prog_data(pdata));

  // Packs {work, mem write, value, skip, flags C Z OV AC SC CZ, table, bump, last page, 5'h00}.
  function automatic logic [31:0] calc(mas_pkg::mas_op_e o, logic [7:0] w, logic [7:0] m, logic [7:0] im,
                                       logic ui, logic [2:0] bs, logic [5:0] f);
    logic [7:0] b, r, v;
    logic [8:0] d;
    logic [1:0] fc;
    logic [2:0] t, ws;
    logic       wb, bt, ov;
    logic [5:0] ef;
    wb = o inside {mas_pkg::OP_SUBTRACT_BORROW_REG, mas_pkg::OP_SUBTRACT_BORROW_TO_MEMORY};
    bt = wb & ~f[5];
    b = (ui && o inside {mas_pkg::OP_SUBTRACT_BORROW_REG, mas_pkg::OP_SUBTRACT_REG,
                         mas_pkg::OP_EXCLUSIVE_OR_REG}) ? im : m;
    d = {1'b0, w} - {1'b0, b} - {8'h00, bt};
    r = d[7:0];
    ov = (w[7] ^ b[7]) & (w[7] ^ r[7]);
    t = 3'h0;
    case (o)
      mas_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING: {fc, ws, v} = {2'h3, 3'h4, f[5], m[7:1]};
      mas_pkg::OP_SUBTRACT_BORROW_REG, mas_pkg::OP_SUBTRACT_REG: {fc, ws, v} = {2'h1, 3'h4, r};
      mas_pkg::OP_SUBTRACT_BORROW_TO_MEMORY, mas_pkg::OP_SUBTRACT_TO_MEMORY: {fc, ws, v} = {2'h1, 3'h2, r};
      mas_pkg::OP_DECREMENT_SKIP_NULL: {fc, ws, v} = {4'h1, m == 8'h01, m - 8'h01};
      mas_pkg::OP_DECREMENT_SKIP_NULL_TO_WORKING: {fc, ws, v} = {4'h2, m == 8'h01, m - 8'h01};
      mas_pkg::OP_INCREMENT_SKIP_NULL: {fc, ws, v} = {4'h1, m == 8'hFF, m + 8'h01};
      mas_pkg::OP_INCREMENT_SKIP_NULL_TO_WORKING: {fc, ws, v} = {4'h2, m == 8'hFF, m + 8'h01};
      mas_pkg::OP_SKIP_NONNULL: {fc, ws, v} = {4'h0, m != 8'h00, m};
      mas_pkg::OP_SKIP_NONNULL_BIT: {fc, ws, v} = {4'h0, m[bs], m};
      mas_pkg::OP_SKIP_ON_NULL: {fc, ws, v} = {4'h0, m == 8'h00, m};
      mas_pkg::OP_SKIP_ON_NULL_BIT: {fc, ws, v} = {4'h0, ~m[bs], m};
      mas_pkg::OP_COPY_SKIP_ON_NULL: {fc, ws, v} = {4'h2, m == 8'h00, m};
      mas_pkg::OP_SET_ALL: {fc, ws, v} = {5'h02, 8'hFF};
      mas_pkg::OP_SET_BIT: {fc, ws, v} = {5'h02, m | (8'h01 << bs)};
      mas_pkg::OP_NIBBLE_SWAP: {fc, ws, v} = {5'h02, m[3:0], m[7:4]};
      mas_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING: {fc, ws, v} = {5'h04, m[3:0], m[7:4]};
      mas_pkg::OP_EXCLUSIVE_OR_REG: {fc, ws, v} = {2'h2, 3'h4, w ^ b};
      mas_pkg::OP_EXCLUSIVE_OR_TO_MEMORY: {fc, ws, v} = {2'h2, 3'h2, w ^ b};
      mas_pkg::OP_PROGRAM_WORD_FETCH: {t, fc, ws, v} = {3'h4, 5'h00, m};
      mas_pkg::OP_LAST_PAGE_WORD_FETCH: {t, fc, ws, v} = {3'h5, 5'h00, m};
      mas_pkg::OP_POINTER_BUMP_WORD_FETCH: {t, fc, ws, v} = {3'h6, 5'h00, m};
      mas_pkg::OP_POINTER_BUMP_LAST_PAGE_FETCH: {t, fc, ws, v} = {3'h7, 5'h00, m};
      default: {fc, ws, v} = {5'h00, m};
    endcase
    ef = f;
    if (fc == 2'h1) ef = {~d[8], r == 8'h00, ov, {1'b0, w[3:0]} >= {1'b0, b[3:0]} + {4'h0, bt}, ~(ov ^ r[7]),
                          (r == 8'h00) & (~wb | f[0])};
    if (fc == 2'h2) ef[4] = v == 8'h00;
    if (fc == 2'h3) ef[5] = m[0];
    return {ws[2] ? v : w, ws[1], v, ws[0], ef, t, 5'h00};
  endfunction

  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic verify(logic [31:0] e, logic [7:0] a, logic [12:0] pa);
    #1;
    cmp(work, e[31:24]);
    cmp({m_we, skip, ready}, {e[23], e[14], ~(e[14] | e[7])});
    if (e[23]) cmp({m_wa, m_wd}, {a, e[22:15]});
    cmp({f_c, f_z, f_ov, f_ac, f_sc, f_cz}, e[13:8]);
    if (e[7]) begin
      cmp({p_rd, paddr, p_lo}, {1'b1, pa, pa[7:0]});
      @(posedge clk_sys);
      #1;
      cmp({m_we, m_wa, m_wd, latch}, {1'b1, a, pa[7:0], 3'h5, pa[12:8]});
    end
  endtask

  // Holds the request until the design is ready; the check runs alongside so the next op can follow at once.
  task automatic run_op(mas_pkg::mas_op_e o, logic [7:0] a, logic [7:0] im, logic ui, logic [2:0] bs);
    logic [31:0] e;
    logic [12:0] pa;
    op_valid <= 1'b1;
    op_code <= o;
    addr <= a;
    imm <= im;
    use_imm <= ui;
    bsel <= bs;
    #1;
    while (ready !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    e = calc(o, work, rdata, im, ui, bs, {f_c, f_z, f_ov, f_ac, f_sc, f_cz});
    pa = {e[5] ? mas_pkg::LAST_PAGE : hi_x[4:0], lo_x + {7'h00, e[6]}};
    lo_x = pa[7:0];
    @(posedge clk_sys);
    fork
      verify(e, a, pa);
    join_none
  endtask

  task automatic load(logic [7:0] w, logic [7:0] p, logic [3:0] en);
    op_valid <= 1'b0;
    {w_ld, c_ld, pl_ld, ph_ld} <= en;
    w_wd <= w;
    p_wd <= p;
    c_wd <= w[0];
    {lo_x, hi_x} = {en[1] ? p : lo_x, en[0] ? p : hi_x};
    @(posedge clk_sys);
    {w_ld, c_ld, pl_ld, ph_ld} <= 4'h0;
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    end_sim;
  end

  initial begin
    {rst_b, op_valid, use_imm, c_ld, c_wd, w_ld, pl_ld, ph_ld} = 8'h00;
    op_code = mas_pkg::OP_NONE;
    {imm, addr, w_wd, p_wd, bsel, lo_x, hi_x} = 51'h0;
    repeat (16) @(posedge clk_sys);
    cmp({work, p_lo, p_hi, latch}, 32'h0);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    load(8'h80, 8'hFF, 4'hF);
    run_op(mas_pkg::OP_SUBTRACT_REG, 8'h10, 8'h01, 1'b1, 3'h7);
    run_op(mas_pkg::OP_SET_ALL, 8'h10, 8'h01, 1'b1, 3'h7);
    run_op(mas_pkg::OP_INCREMENT_SKIP_NULL, 8'h10, 8'h01, 1'b1, 3'h7);
    run_op(mas_pkg::OP_SKIP_NONNULL_BIT, 8'h10, 8'h01, 1'b1, 3'h7);
    run_op(mas_pkg::OP_DECREMENT_SKIP_NULL, 8'h10, 8'h01, 1'b1, 3'h7);
    run_op(mas_pkg::OP_POINTER_BUMP_WORD_FETCH, 8'h10, 8'h01, 1'b1, 3'h7);
    $display("corner test done");
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      if (r[31:30] == 2'b00) load(r[7:0], r[15:8], r[23:20]);
      r = $random(seed);
      run_op(mas_pkg::mas_op_e'(5'h01 + 5'(r[15:0] % 24)), r[23:16], r[7:0], r[31], r[26:24]);
    end
    $display("random test done");
    op_valid <= 1'b0;
    @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    end_sim;
  end
endmodule
